// ---- hdl/osdts_pkg.sv ----
package osdts_pkg;
	// ==========================================
	// Register offsets (byte addresses, word aligned)
	localparam logic [5:0] ADDR_STATUS     = 6'h00;
	localparam logic [5:0] ADDR_HSYNC_LAG  = 6'h04;
	localparam logic [5:0] ADDR_VSYNC_LAG  = 6'h08;
	localparam logic [5:0] ADDR_TOP_LINE   = 6'h0C;
	localparam logic [5:0] ADDR_CONFIG     = 6'h10;
	localparam logic [5:0] ADDR_PB_START   = 6'h14;
	localparam logic [5:0] ADDR_PB_END     = 6'h18;
	localparam logic [5:0] ADDR_PB_PLACE   = 6'h1C;
	localparam logic [5:0] ADDR_PB_VOFF    = 6'h20;
	localparam logic [5:0] ADDR_PA_VOFF    = 6'h24;
	localparam logic [5:0] ADDR_IRQ_STATUS = 6'h28;
	localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h2C;
	localparam logic [5:0] ADDR_IRQ_CLEAR  = 6'h30;
	localparam logic [5:0] ADDR_MODE_CTRL  = 6'h34;
	// ==========================================
	// Status fields
	localparam int ST_BUSY     = 7;
	localparam int ST_FIELD    = 6;
	localparam int ST_ROLL_EN  = 5;
	localparam int ST_FLASH    = 4;
	// Configuration fields
	localparam int CF_CAPTION  = 7;
	localparam int CF_LAG_HI   = 6;
	localparam int CF_LAG_LO   = 4;
	localparam int CF_AXIS     = 3;
	localparam int CF_CAPFIELD = 2;
	localparam int CF_HIRATE   = 1;
	localparam int CF_DUAL     = 0;
	// Interrupt bits
	localparam int IRQ_VSYNC   = 0;
	localparam int IRQ_HSYNC   = 1;
	localparam int IRQ_BUSY    = 2;
	// ==========================================
	// Reset values and timing
	localparam logic [7:0] REG_RESET    = 8'h00;
	localparam int         LAG_W        = 7;
	localparam int         VLAG_UNIT    = 8;
	localparam int         CHAR_PIXELS  = 12;
	localparam real        PIX_CLK_MHZ  = 12.0;
	localparam real        SYS_CLK_MHZ  = 250.0;
	localparam int         PIX_DIV      = int'(SYS_CLK_MHZ / PIX_CLK_MHZ);
	// Switch alignment codes
	localparam logic [2:0] SW_OFF       = 3'h0;
	localparam logic [2:0] SW_EARLY     = 3'h1;
	localparam logic [2:0] SW_ALIGNED   = 3'h2;
	localparam logic [2:0] SW_LATE      = 3'h4;
endpackage

// ---- hdl/osdts_regs.sv ----
// Functional notes
// - Busy status bit is 1 while display memory access may disturb the picture.
// - Field parity flag comes from H and V syncs; 1 means even field.
// - In progressive scan the field parity toggles at every vertical sync.
// - Flash-region-only bit shows background only in flash regions; reads back.
// - Roll enable bit and four-bit first rolling row are read/write in status.
// - Horizontal sync delayed by seven-bit count in full character widths.
// - Vertical sync delayed by seven-bit count in units of eight pixel clocks.
// - Caption mode bit selects closed caption operation.
// - Switch lag code: 000 off, 001 early, 010 aligned, 100 late.
// - Busy axis bit 1 makes busy follow horizontal timing.
// - Capture field flag is read-only from composite input; writes ignored.
// - High-rate bit selects 100 or 120 Hz display timing.
// - Dual window bit enables two-page mode with second page window registers.
// - Second page takes two-bit fine offset and six-bit text start.
// - Second page text area ends at six-bit full-character position.
// - First page six-bit vertical offset gives display start lines after sync.
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module osdts_regs
#(
	parameter int LAG_W = 7
)
(
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        hsyncPin,
	input  wire logic        vsyncPin,
	input  wire logic        captureFieldPin,
	input  wire logic        memAccessReq,
	input  wire logic        videoRgbActive,
	output logic             lagHsync_r,
	output logic             lagVsync_r,
	output logic             videoSwitchOut_r,
	output logic             busyTiming_r,
	output logic             captionMode_r,
	output logic             hiRate_r,
	output logic             dualWindow_r,
	output logic             flashRegionOnly_r,
	output logic             rollAreaEnable_r,
	output logic [3:0]       firstRollingRow_r,
	output logic [3:0]       rollTopLineSel_r,
	output logic [1:0]       pbFineOffset_r,
	output logic [5:0]       pbStartCol_r,
	output logic [5:0]       pbEndCol_r,
	output logic [7:0]       pbPlace_r,
	output logic [5:0]       pbLineOffset_r,
	output logic [5:0]       paLineOffset_r,
	output logic             pbLineMatch_r,
	output logic             irq_r
);
	// ==========================================
	// Pin synchronisers
	logic [2:0] hsSync_r;
	logic [2:0] vsSync_r;
	logic [2:0] cfSync_r;
	logic       hsLevel_r;
	logic       vsLevel_r;
	logic       cfLevel_r;
	logic       hsRise;
	logic       vsRise;

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			hsSync_r <= 3'h0;
			vsSync_r <= 3'h0;
			cfSync_r <= 3'h0;
			hsLevel_r <= 1'b0;
			vsLevel_r <= 1'b0;
			cfLevel_r <= 1'b0;
		end
		else
		begin
			hsSync_r <= {hsSync_r[1:0], hsyncPin};
			vsSync_r <= {vsSync_r[1:0], vsyncPin};
			cfSync_r <= {cfSync_r[1:0], captureFieldPin};
			if (hsSync_r[1] == hsSync_r[2])
				hsLevel_r <= hsSync_r[2];
			if (vsSync_r[1] == vsSync_r[2])
				vsLevel_r <= vsSync_r[2];
			if (cfSync_r[1] == cfSync_r[2])
				cfLevel_r <= cfSync_r[2];
		end
	end

	assign hsRise = (hsSync_r[1] == hsSync_r[2]) && hsSync_r[2] && !hsLevel_r;
	assign vsRise = (vsSync_r[1] == vsSync_r[2]) && vsSync_r[2] && !vsLevel_r;

	// ==========================================
	// Registers
	logic [LAG_W-1:0] hLag_r;
	logic [LAG_W-1:0] vLag_r;
	logic [2:0]       switchLag_r;
	logic             busyAxis_r;
	logic             progressive_r;
	logic [2:0]       irqStatus_r;
	logic [2:0]       irqEnable_r;
	logic             busyFlag_r;
	logic             fieldParity_r;
	logic             wrEn;
	logic [7:0]       wb;

	assign wrEn = avs_write && !avs_waitrequest && avs_byteenable[0];
	assign wb   = avs_writedata[7:0];

	function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
		hit = (a == o);
	endfunction

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			hLag_r <= '0;
			vLag_r <= '0;
			switchLag_r <= 3'h0;
			busyAxis_r <= 1'b0;
			progressive_r <= 1'b0;
			captionMode_r <= 1'b0;
			hiRate_r <= 1'b0;
			dualWindow_r <= 1'b0;
			flashRegionOnly_r <= 1'b0;
			rollAreaEnable_r <= 1'b0;
			firstRollingRow_r <= 4'h0;
			rollTopLineSel_r <= 4'h0;
			pbFineOffset_r <= 2'h0;
			pbStartCol_r <= 6'h00;
			pbEndCol_r <= 6'h00;
			pbPlace_r <= 8'h00;
			pbLineOffset_r <= 6'h00;
			paLineOffset_r <= 6'h00;
			irqEnable_r <= 3'h0;
		end
		else if (wrEn)
		begin
			if (hit(avs_address, osdts_pkg::ADDR_STATUS))
			begin
				rollAreaEnable_r <= wb[osdts_pkg::ST_ROLL_EN];
				flashRegionOnly_r <= wb[osdts_pkg::ST_FLASH];
				firstRollingRow_r <= wb[3:0];
			end
			if (hit(avs_address, osdts_pkg::ADDR_HSYNC_LAG))
				hLag_r <= wb[LAG_W-1:0];
			if (hit(avs_address, osdts_pkg::ADDR_VSYNC_LAG))
				vLag_r <= wb[LAG_W-1:0];
			if (hit(avs_address, osdts_pkg::ADDR_TOP_LINE))
				rollTopLineSel_r <= wb[3:0];
			if (hit(avs_address, osdts_pkg::ADDR_CONFIG))
			begin
				captionMode_r <= wb[osdts_pkg::CF_CAPTION];
				switchLag_r <= wb[osdts_pkg::CF_LAG_HI:osdts_pkg::CF_LAG_LO];
				busyAxis_r <= wb[osdts_pkg::CF_AXIS];
				hiRate_r <= wb[osdts_pkg::CF_HIRATE];
				dualWindow_r <= wb[osdts_pkg::CF_DUAL];
			end
			if (hit(avs_address, osdts_pkg::ADDR_PB_START))
			begin
				pbFineOffset_r <= wb[7:6];
				pbStartCol_r <= wb[5:0];
			end
			if (hit(avs_address, osdts_pkg::ADDR_PB_END))
				pbEndCol_r <= wb[5:0];
			if (hit(avs_address, osdts_pkg::ADDR_PB_PLACE))
				pbPlace_r <= wb;
			if (hit(avs_address, osdts_pkg::ADDR_PB_VOFF))
				pbLineOffset_r <= wb[5:0];
			if (hit(avs_address, osdts_pkg::ADDR_PA_VOFF))
				paLineOffset_r <= wb[5:0];
			if (hit(avs_address, osdts_pkg::ADDR_IRQ_ENABLE))
				irqEnable_r <= wb[2:0];
			if (hit(avs_address, osdts_pkg::ADDR_MODE_CTRL))
				progressive_r <= wb[0];
		end
	end

	// ==========================================
	// Pixel clock enable and sync delays
	logic [7:0]       pixCnt_r;
	logic             pixTick;
	logic [3:0]       charCnt_r;
	logic [2:0]       unitCnt_r;
	logic [LAG_W-1:0] hCnt_r;
	logic [LAG_W-1:0] vCnt_r;
	logic             hRun_r;
	logic             vRun_r;
	logic             hDone;
	logic             vDone;

	assign pixTick = (pixCnt_r == 8'(osdts_pkg::PIX_DIV - 1));

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			pixCnt_r <= 8'h00;
		else if (pixTick)
			pixCnt_r <= 8'h00;
		else
			pixCnt_r <= pixCnt_r + 8'h01;
	end

	assign hDone = hRun_r && pixTick && (charCnt_r == 4'(osdts_pkg::CHAR_PIXELS - 1)) && (hCnt_r == '0);
	assign vDone = vRun_r && pixTick && (unitCnt_r == 3'(osdts_pkg::VLAG_UNIT - 1)) && (vCnt_r == '0);

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			hRun_r <= 1'b0;
			hCnt_r <= '0;
			charCnt_r <= 4'h0;
			lagHsync_r <= 1'b0;
		end
		else
		begin
			lagHsync_r <= 1'b0;
			if (hsRise)
			begin
				hCnt_r <= hLag_r;
				charCnt_r <= 4'h0;
				hRun_r <= (hLag_r != '0);
				lagHsync_r <= (hLag_r == '0);
			end
			else if (hRun_r && pixTick)
			begin
				if (charCnt_r == 4'(osdts_pkg::CHAR_PIXELS - 1))
				begin
					charCnt_r <= 4'h0;
					if (hCnt_r == LAG_W'(1) || hCnt_r == '0)
					begin
						hRun_r <= 1'b0;
						lagHsync_r <= 1'b1;
					end
					hCnt_r <= hCnt_r - 1'b1;
				end
				else
					charCnt_r <= charCnt_r + 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			vRun_r <= 1'b0;
			vCnt_r <= '0;
			unitCnt_r <= 3'h0;
			lagVsync_r <= 1'b0;
		end
		else
		begin
			lagVsync_r <= 1'b0;
			if (vsRise)
			begin
				vCnt_r <= vLag_r;
				unitCnt_r <= 3'h0;
				vRun_r <= (vLag_r != '0);
				lagVsync_r <= (vLag_r == '0);
			end
			else if (vRun_r && pixTick)
			begin
				if (unitCnt_r == 3'(osdts_pkg::VLAG_UNIT - 1))
				begin
					unitCnt_r <= 3'h0;
					if (vCnt_r == LAG_W'(1) || vCnt_r == '0)
					begin
						vRun_r <= 1'b0;
						lagVsync_r <= 1'b1;
					end
					vCnt_r <= vCnt_r - 1'b1;
				end
				else
					unitCnt_r <= unitCnt_r + 3'h1;
			end
		end
	end

	// ==========================================
	// Field parity, busy and line matching
	logic       hsDuringV_r;
	logic [5:0] lineCnt_r;

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			fieldParity_r <= 1'b0;
			hsDuringV_r <= 1'b0;
		end
		else if (vsRise)
		begin
			if (progressive_r)
				fieldParity_r <= !fieldParity_r;
			// even field when vsync lands mid-line
			else
				fieldParity_r <= hsDuringV_r;
			hsDuringV_r <= 1'b0;
		end
		else if (hsRise)
			hsDuringV_r <= 1'b0;
		else if (pixTick)
			hsDuringV_r <= 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			lineCnt_r <= 6'h00;
			pbLineMatch_r <= 1'b0;
		end
		else
		begin
			if (vsRise)
				lineCnt_r <= 6'h00;
			else if (hsRise && lineCnt_r != 6'h3F)
				lineCnt_r <= lineCnt_r + 6'h01;
			// second page starts on its own offset in dual mode
			pbLineMatch_r <= dualWindow_r ? (lineCnt_r == pbLineOffset_r) : (lineCnt_r == paLineOffset_r);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			busyTiming_r <= 1'b0;
			busyFlag_r <= 1'b0;
		end
		else
		begin
			busyTiming_r <= busyAxis_r ? hsLevel_r : vsLevel_r;
			// busy while access meets active timing
			busyFlag_r <= memAccessReq && !(busyAxis_r ? hsLevel_r : vsLevel_r);
		end
	end

	// ==========================================
	// Video switch alignment
	logic [1:0] rgbHist_r;

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			rgbHist_r <= 2'h0;
			videoSwitchOut_r <= 1'b0;
		end
		else
		begin
			// lag codes; early is not predictable so the pipe is two pixels deep
			if (pixTick)
				rgbHist_r <= {rgbHist_r[0], videoRgbActive};
			case (switchLag_r)
				osdts_pkg::SW_EARLY:   videoSwitchOut_r <= videoRgbActive;
				osdts_pkg::SW_ALIGNED: videoSwitchOut_r <= rgbHist_r[0];
				osdts_pkg::SW_LATE:    videoSwitchOut_r <= rgbHist_r[1];
				default:               videoSwitchOut_r <= 1'b0;
			endcase
		end
	end

	// ==========================================
	// Interrupts: set wins over clear
	logic [2:0] irqEvents;
	logic [2:0] irqClear;

	assign irqEvents = {busyFlag_r, lagHsync_r, lagVsync_r};
	assign irqClear  = (wrEn && hit(avs_address, osdts_pkg::ADDR_IRQ_CLEAR)) ? wb[2:0] : 3'h0;

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			irqStatus_r <= 3'h0;
			irq_r <= 1'b0;
		end
		else
		begin
			irqStatus_r <= (irqStatus_r & ~irqClear) | irqEvents;
			irq_r <= |(irqStatus_r & irqEnable_r);
		end
	end

	// ==========================================
	// Bus read and wait
	logic [7:0] rd;

	always_comb
	begin
		rd = osdts_pkg::REG_RESET;
		case (avs_address)
			osdts_pkg::ADDR_STATUS:     rd = {busyFlag_r, fieldParity_r, rollAreaEnable_r, flashRegionOnly_r,
			                                  firstRollingRow_r};
			osdts_pkg::ADDR_HSYNC_LAG:  rd = {1'b0, hLag_r};
			osdts_pkg::ADDR_VSYNC_LAG:  rd = {1'b0, vLag_r};
			osdts_pkg::ADDR_TOP_LINE:   rd = {4'h0, rollTopLineSel_r};
			osdts_pkg::ADDR_CONFIG:     rd = {captionMode_r, switchLag_r, busyAxis_r, cfLevel_r, hiRate_r,
			                                  dualWindow_r};
			osdts_pkg::ADDR_PB_START:   rd = {pbFineOffset_r, pbStartCol_r};
			osdts_pkg::ADDR_PB_END:     rd = {2'h0, pbEndCol_r};
			osdts_pkg::ADDR_PB_PLACE:   rd = pbPlace_r;
			osdts_pkg::ADDR_PB_VOFF:    rd = {2'h0, pbLineOffset_r};
			osdts_pkg::ADDR_PA_VOFF:    rd = {2'h0, paLineOffset_r};
			osdts_pkg::ADDR_IRQ_STATUS: rd = {5'h00, irqStatus_r};
			osdts_pkg::ADDR_IRQ_ENABLE: rd = {5'h00, irqEnable_r};
			osdts_pkg::ADDR_MODE_CTRL:  rd = {7'h00, progressive_r};
			default:                    rd = 8'h00;
		endcase
	end

	// One wait cycle per access: request held, answer on the second edge
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end
		else
		begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest)
				avs_readdata <= {24'h000000, rd};
		end
	end
endmodule

// ---- tb/osdts_checker.sv ----
`timescale 1ns/1ns
module osdts_checker
(
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        lagHsync_r,
	input wire logic        lagVsync_r,
	input wire logic        captionMode_r,
	input wire logic        hiRate_r,
	input wire logic        dualWindow_r,
	input wire logic        flashRegionOnly_r,
	input wire logic        rollAreaEnable_r,
	input wire logic [3:0]  firstRollingRow_r,
	input wire logic [1:0]  pbFineOffset_r,
	input wire logic [5:0]  pbStartCol_r,
	input wire logic        irq_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic       wrDone;
	logic [7:0] wdPrev;
	assign wrDone = avs_write && !avs_waitrequest && avs_byteenable[0];
	// Write data of the completing cycle, seen one edge later
	always_ff @(posedge sys_clk)
		wdPrev <= avs_writedata[7:0];
	// ==========================================
	// Bus handshake
	a_one_wait:
		assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered after one wait");
	a_wait_short:
		assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_rd_upper:
		assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_irq_masked:
		assert property (wrDone && avs_address == osdts_pkg::ADDR_IRQ_ENABLE && avs_writedata[2:0] == 3'h0
			|-> ##2 !irq_r)
		else $error("interrupt stays high with all enables off");
	// ==========================================
	// Register fields
	a_cfg_store:
		assert property (wrDone && avs_address == osdts_pkg::ADDR_CONFIG
			|=> {captionMode_r, hiRate_r, dualWindow_r} == {wdPrev[7], wdPrev[1], wdPrev[0]})
		else $error("config fields not stored");
	a_status_store:
		assert property (wrDone && avs_address == osdts_pkg::ADDR_STATUS
			|=> {rollAreaEnable_r, flashRegionOnly_r, firstRollingRow_r} == wdPrev[5:0])
		else $error("status fields not stored");
	a_pb_start:
		assert property (wrDone && avs_address == osdts_pkg::ADDR_PB_START
			|=> {pbFineOffset_r, pbStartCol_r} == wdPrev)
		else $error("second page start not stored");
	a_hlag_pulse:
		assert property (lagHsync_r |=> !lagHsync_r)
		else $error("delayed hsync longer than one cycle");
	a_vlag_pulse:
		assert property ($rose(lagVsync_r) |=> $fell(lagVsync_r))
		else $error("delayed vsync longer than one cycle");
endmodule

bind osdts_regs osdts_checker u_chk (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lagHsync_r(lagHsync_r),
	.lagVsync_r(lagVsync_r), .captionMode_r(captionMode_r), .hiRate_r(hiRate_r), .dualWindow_r(dualWindow_r),
	.flashRegionOnly_r(flashRegionOnly_r), .rollAreaEnable_r(rollAreaEnable_r),
	.firstRollingRow_r(firstRollingRow_r), .pbFineOffset_r(pbFineOffset_r), .pbStartCol_r(pbStartCol_r),
	.irq_r(irq_r));

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic        hsyncPin = 1'b0;
	logic        vsyncPin = 1'b0;
	logic        captureFieldPin = 1'b0;
	logic        memAccessReq = 1'b0;
	logic        videoRgbActive = 1'b0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, lagHsync_r, lagVsync_r, videoSwitchOut_r, busyTiming_r, irq_r, pbLineMatch_r;
	logic        captionMode_r, hiRate_r, dualWindow_r, flashRegionOnly_r, rollAreaEnable_r;
	logic [3:0]  firstRollingRow_r, rollTopLineSel_r;
	logic [1:0]  pbFineOffset_r;
	logic [5:0]  pbStartCol_r, pbEndCol_r, pbLineOffset_r, paLineOffset_r;
	logic [7:0]  pbPlace_r, q;
	logic [7:0]  mdl [0:15] = '{default: 8'h00};
	logic [2:0]  codes [4] = '{osdts_pkg::SW_OFF, osdts_pkg::SW_EARLY, osdts_pkg::SW_ALIGNED, osdts_pkg::SW_LATE};
	logic        f1, f2;
	int          d0, d1, cycles = 0, miscompares = 0, cmp_count = 0, seed = 32'h6dd3;

	osdts_regs dut (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .hsyncPin, .vsyncPin, .captureFieldPin, .memAccessReq, .videoRgbActive,
		.lagHsync_r, .lagVsync_r, .videoSwitchOut_r, .busyTiming_r, .captionMode_r, .hiRate_r, .dualWindow_r,
		.flashRegionOnly_r, .rollAreaEnable_r, .firstRollingRow_r, .rollTopLineSel_r, .pbFineOffset_r,
		.pbStartCol_r, .pbEndCol_r, .pbPlace_r, .pbLineOffset_r, .paLineOffset_r, .pbLineMatch_r, .irq_r);

	initial
		forever #2 sys_clk = ~sys_clk;

	// ==========================================
	// Model and bus tasks
	function automatic logic [7:0] wmask(input logic [3:0] i);
		case (i)
			0: return 8'h3F;
			1, 2: return 8'h7F;
			3: return 8'h0F;
			4: return 8'hFB;
			5, 7: return 8'hFF;
			6, 8, 9: return 8'h3F;
			11: return 8'h07;
			13: return 8'h01;
			default: return 8'h00;
		endcase
	endfunction

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// Held until waitrequest is sampled low; the watchdog ends a hang
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] r);
		@(posedge sys_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		do
			@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0);
		r = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, a, d, r);
		if (avs_byteenable[0])
			mdl[a[5:2]] = d & wmask(a[5:2]);
	endtask

	task automatic rdall;
		logic [7:0] r;
		for (int i = 0; i < 16; i++)
		begin
			bus(1'b0, 6'(i * 4), 8'h00, r);
			chk($sformatf("reg %0h", i * 4), {56'h0, mdl[i]}, {56'h0, r});
		end
	endtask

	// Time from sync pin rise to the delayed pulse
	task automatic lag(input logic h, input logic [6:0] n, output int d);
		wr(h ? osdts_pkg::ADDR_HSYNC_LAG : osdts_pkg::ADDR_VSYNC_LAG, {1'b0, n});
		d = 0;
		hsyncPin <= h;
		vsyncPin <= !h;
		do
		begin
			@(posedge sys_clk);
			d++;
		end
		while ((h ? lagHsync_r : lagVsync_r) !== 1'b1);
		hsyncPin <= 1'b0;
		vsyncPin <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	// ==========================================
	// Scenarios
	initial
	begin
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		rdall();
		for (int i = 0; i < 40; i++)
			wr(6'($random(seed)) & 6'h3C, 8'($random(seed)));
		wr(osdts_pkg::ADDR_CONFIG, 8'hFF);
		wr(osdts_pkg::ADDR_STATUS, 8'hFF);
		avs_byteenable <= 4'h0;
		wr(osdts_pkg::ADDR_PB_PLACE, 8'($random(seed)));
		avs_byteenable <= 4'h1;
		rdall();
		chk("fields", {mdl[4][7], mdl[4][1], mdl[4][0], mdl[0][4], mdl[0][5], mdl[0][3:0], mdl[3][3:0], mdl[5],
			mdl[6][5:0], mdl[7], mdl[8][5:0], mdl[9][5:0]}, {captionMode_r, hiRate_r, dualWindow_r,
			flashRegionOnly_r, rollAreaEnable_r, firstRollingRow_r, rollTopLineSel_r, pbFineOffset_r,
			pbStartCol_r, pbEndCol_r, pbPlace_r, pbLineOffset_r, paLineOffset_r});
		wr(osdts_pkg::ADDR_IRQ_CLEAR, 8'h07);
		wr(osdts_pkg::ADDR_IRQ_ENABLE, 8'h02);
		wr(osdts_pkg::ADDR_MODE_CTRL, 8'h01);
		lag(1'b1, 7'h00, d0);
		lag(1'b1, 7'h05, d1);
		d0 = d1 - d0 - 5 * osdts_pkg::CHAR_PIXELS * osdts_pkg::PIX_DIV;
		chk("hsync lag", 64'h1, 64'(d0 >= -osdts_pkg::PIX_DIV && d0 <= osdts_pkg::PIX_DIV));
		lag(1'b0, 7'h00, d0);
		bus(1'b0, osdts_pkg::ADDR_STATUS, 8'h00, q);
		f1 = q[osdts_pkg::ST_FIELD];
		lag(1'b0, 7'h05, d1);
		bus(1'b0, osdts_pkg::ADDR_STATUS, 8'h00, q);
		f2 = q[osdts_pkg::ST_FIELD];
		d0 = d1 - d0 - 5 * osdts_pkg::VLAG_UNIT * osdts_pkg::PIX_DIV;
		chk("vsync lag", 64'h1, 64'(d0 >= -osdts_pkg::PIX_DIV && d0 <= osdts_pkg::PIX_DIV));
		chk("field toggle", {63'h0, !f1}, {63'h0, f2});
		chk("irq high", 64'h1, {63'h0, irq_r});
		bus(1'b0, osdts_pkg::ADDR_IRQ_STATUS, 8'h00, q);
		chk("irq status", 64'h3, {56'h0, q});
		wr(osdts_pkg::ADDR_IRQ_ENABLE, 8'h00);
		repeat (2) @(posedge sys_clk);
		chk("irq masked", 64'h0, {63'h0, irq_r});
		wr(osdts_pkg::ADDR_IRQ_CLEAR, 8'h03);
		bus(1'b0, osdts_pkg::ADDR_IRQ_STATUS, 8'h00, q);
		chk("irq cleared", 64'h0, {56'h0, q});
		memAccessReq <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			wr(osdts_pkg::ADDR_CONFIG, {4'h0, k[1], 3'h0});
			hsyncPin <= k[1] & k[0];
			vsyncPin <= !k[1] & k[0];
			repeat (6) @(posedge sys_clk);
			bus(1'b0, osdts_pkg::ADDR_STATUS, 8'h00, q);
			chk("busy", {63'h0, !k[0]}, {63'h0, q[osdts_pkg::ST_BUSY]});
			chk("busy timing", {63'h0, k[0]}, {63'h0, busyTiming_r});
		end
		memAccessReq <= 1'b0;
		hsyncPin <= 1'b0;
		vsyncPin <= 1'b0;
		// Wait covers the late code, two pixel clocks behind
		for (int j = 0; j < 4; j++)
		begin
			wr(osdts_pkg::ADDR_CONFIG, {1'b0, codes[j], 4'h0});
			for (int v = 1; v >= 0; v--)
			begin
				videoRgbActive <= v[0];
				repeat (3 * osdts_pkg::PIX_DIV + 4) @(posedge sys_clk);
				chk("switch", {63'h0, v[0] && codes[j] != 3'h0}, {63'h0, videoSwitchOut_r});
			end
		end
		wr(osdts_pkg::ADDR_MODE_CTRL, 8'h00);
		wr(osdts_pkg::ADDR_PA_VOFF, 8'h01);
		wr(osdts_pkg::ADDR_PB_VOFF, 8'h01);
		wr(osdts_pkg::ADDR_CONFIG, 8'h01);
		for (int s = 0; s < 2; s++)
		begin
			hsyncPin <= s[0];
			vsyncPin <= !s[0];
			repeat (8) @(posedge sys_clk);
			chk("line match", {63'h0, s[0]}, {63'h0, pbLineMatch_r});
			hsyncPin <= 1'b0;
			vsyncPin <= 1'b0;
			repeat (8) @(posedge sys_clk);
		end
		bus(1'b0, osdts_pkg::ADDR_STATUS, 8'h00, q);
		chk("field even", 64'h1, {63'h0, q[osdts_pkg::ST_FIELD]});
		wrap_up();
	end
endmodule
